// >>> verilog/trig_seq_pkg.sv
// Package for the timing trigger sequencer: register map, fields, counts.
// Assumes a 100 MHz sampling clock and a 32-bit APB register bus.
package trig_seq_pkg;
	// ****************************************************
	// Sizes
	// ****************************************************
	localparam int LINES = 8;
	localparam int LEVELS = 4;
	localparam int LVL_W = 2;
	localparam int CNT_W = 16;
	localparam int TMR_W = 16;
	localparam int CLK_PERIOD_NS = 10;
	// Example figures, kept in their own units
	localparam int MIN_DUR_NS = 80;
	localparam int MIN_DUR_CYC = (MIN_DUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_LIMIT_US = 16;
	localparam int ACK_LIMIT_CYC = ACK_LIMIT_US * 1000 / CLK_PERIOD_NS;
	localparam int MIN_WID_NS = 496;
	localparam int MIN_WID_CYC = (MIN_WID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_WID_US = 1;
	localparam int MAX_WID_CYC = MAX_WID_US * 1000 / CLK_PERIOD_NS;
	localparam int EDGE_COUNT_EX = 10;
	// ****************************************************
	// Register offsets
	// ****************************************************
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] TERM_OFF = 8'h08;
	localparam logic [7:0] PAT_OFF = 8'h0c;
	localparam logic [7:0] TMR1_OFF = 8'h10;
	localparam logic [7:0] TMR2_OFF = 8'h14;
	localparam logic [7:0] LVL_BASE = 8'h20;
	// ****************************************************
	// Fields
	// ****************************************************
	localparam int CTRL_RUN = 0;
	localparam int CTRL_LAST_LSB = 4;
	localparam int TERM_E1_LINE = 0;
	localparam int TERM_E1_MODE = 4;
	localparam int TERM_E2_LINE = 8;
	localparam int TERM_E2_MODE = 12;
	localparam int PAT_VAL = 0;
	localparam int PAT_MASK = 8;
	localparam int PAT_DUR = 16;
	// Level word: primary[3:0] else[7:4] else target[9:8] timer start[11:10]
	// count[31:16]
	localparam int LV_PRI = 0;
	localparam int LV_ELS = 4;
	localparam int LV_TGT = 8;
	localparam int LV_TST = 10;
	localparam int LV_CNT = 16;
	// Edge modes
	localparam logic [1:0] EDGE_ASSERT = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;
	// Term select codes
	localparam logic [3:0] T_NONE = 4'h0;
	localparam logic [3:0] T_ANY = 4'h1;
	localparam logic [3:0] T_E1 = 4'h2;
	localparam logic [3:0] T_E2 = 4'h3;
	localparam logic [3:0] T_PAT = 4'h4;
	localparam logic [3:0] T_NPAT = 4'h5;
	localparam logic [3:0] T_TMR1 = 4'h6;
	localparam logic [3:0] T_TMR2 = 4'h7;
	localparam logic [3:0] T_NTMR1 = 4'h8;
	localparam logic [3:0] T_T1LO_T2HI = 4'h9;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIG} seq_state_t;
endpackage

// >>> verilog/trig_seq.sv
// Timing trigger sequencer: sequence levels over sampled signal lines.
// Assumes lines_i synchronous to clock_i; software programs it over APB.
// Operation
// - Edge term with count N triggers only on the Nth matching transition.
// - Edge terms match asserting, positive-going or negative-going transition.
// - Pattern with duration holds only after lasting longer than limit.
// - Level advances after primary term occurs the programmed number of times.
// - Else term met first jumps to its target level.
// - Two interval timers start when a chosen level is entered, except level 0 at run start.
// - Timer term true once timer exceeds its programmed limit.
// - Falling edge meeting level two moves sequencer to level three.
// - Level three triggers on short minimum or long maximum, else restarts.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module trig_seq
	import trig_seq_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Lines of the system under test
	input wire logic [LINES-1:0] lines_i,
	// Trigger
	output logic trigger_o
);
	// ****************************************************
	// Registers
	// ****************************************************
	logic [31:0] ctrl;
	logic [31:0] term_cfg;
	logic [31:0] pat_cfg;
	logic [TMR_W-1:0] tmr1_lim;
	logic [TMR_W-1:0] tmr2_lim;
	logic [31:0] lvl_cfg [LEVELS];
	logic [LINES-1:0] prev_lines;
	logic [7:0] pat_run;
	logic [TMR_W-1:0] first_interval_timer;
	logic [TMR_W-1:0] second_interval_timer;
	logic t1_on;
	logic t2_on;
	logic [CNT_W-1:0] occ;
	logic [LVL_W-1:0] level;
	seq_state_t state;
	logic run_q;

	// ****************************************************
	// Bus decode
	// ****************************************************
	wire wr_en = psel_i && penable_i && pwrite_i;
	wire rd_en = psel_i && penable_i && !pwrite_i;
	wire hit_ctrl = paddr_i == CTRL_OFF;
	wire hit_stat = paddr_i == STAT_OFF;
	wire hit_term = paddr_i == TERM_OFF;
	wire hit_pat = paddr_i == PAT_OFF;
	wire hit_t1 = paddr_i == TMR1_OFF;
	wire hit_t2 = paddr_i == TMR2_OFF;
	wire hit_lvl = paddr_i[7:4] == LVL_BASE[7:4] && paddr_i[1:0] == 2'h0;
	wire [LVL_W-1:0] lvl_idx = paddr_i[LVL_W+1:2];
	wire hit_any = hit_ctrl || hit_stat || hit_term || hit_pat || hit_t1
		|| hit_t2 || hit_lvl;
	logic [31:0] rd_mux;
	assign rd_mux = hit_ctrl ? ctrl :
		hit_stat ? {16'h0, occ[7:0], 2'h0, level, 2'h0, state} :
		hit_term ? term_cfg :
		hit_pat ? pat_cfg :
		hit_t1 ? {16'h0, tmr1_lim} :
		hit_t2 ? {16'h0, tmr2_lim} :
		hit_lvl ? lvl_cfg[lvl_idx] : 32'h0;

	// ****************************************************
	// Term evaluation
	// ****************************************************
	wire run_bit = ctrl[CTRL_RUN];
	wire [LVL_W-1:0] last_lvl = ctrl[CTRL_LAST_LSB +: LVL_W];
	wire [2:0] e1_line = term_cfg[TERM_E1_LINE +: 3];
	wire [1:0] e1_mode = term_cfg[TERM_E1_MODE +: 2];
	wire [2:0] e2_line = term_cfg[TERM_E2_LINE +: 3];
	wire [1:0] e2_mode = term_cfg[TERM_E2_MODE +: 2];
	// Asserting means the line goes to its active level, taken as high here
	wire e1_rise = lines_i[e1_line] && !prev_lines[e1_line];
	wire e1_fall = !lines_i[e1_line] && prev_lines[e1_line];
	wire e2_rise = lines_i[e2_line] && !prev_lines[e2_line];
	wire e2_fall = !lines_i[e2_line] && prev_lines[e2_line];
	wire first_transition_term = (e1_mode == EDGE_FALL) ? e1_fall :
		(e1_mode == EDGE_ANY) ? (e1_rise || e1_fall) : e1_rise;
	wire second_transition_term = (e2_mode == EDGE_FALL) ? e2_fall :
		(e2_mode == EDGE_ANY) ? (e2_rise || e2_fall) : e2_rise;
	wire [7:0] pat_val = pat_cfg[PAT_VAL +: 8];
	wire [7:0] pat_mask = pat_cfg[PAT_MASK +: 8];
	wire [7:0] pat_dur = pat_cfg[PAT_DUR +: 8];
	wire pat_now = ((lines_i ^ pat_val) & pat_mask) == 8'h0;
	// Pattern must have stood longer than the duration, not equal to it
	wire pat_term = pat_now && (pat_run > pat_dur);
	wire tmr1_term = t1_on && (first_interval_timer > tmr1_lim);
	wire tmr2_term = t2_on && (second_interval_timer > tmr2_lim);
	wire tmr1_short = t1_on && (first_interval_timer < tmr1_lim);
	// Terms indexed by select code; a vector keeps every term in view
	// of the continuous assignments, unlike a function reading globals
	wire [15:0] term_vec = {6'h0,
		tmr1_short || tmr2_term,
		!tmr1_term, tmr2_term, tmr1_term, !pat_now, pat_term,
		second_transition_term, first_transition_term, 1'b1, 1'b0};
	wire [31:0] cur_cfg = lvl_cfg[level];
	wire pri_hit = term_vec[cur_cfg[LV_PRI +: 4]];
	wire els_hit = term_vec[cur_cfg[LV_ELS +: 4]];
	wire [LVL_W-1:0] els_tgt = cur_cfg[LV_TGT +: LVL_W];
	wire [CNT_W-1:0] need = cur_cfg[LV_CNT +: CNT_W];
	// Count of zero is treated as one occurrence
	wire count_done = pri_hit && ({16'h0, occ} + 32'h1 >= {16'h0, need});
	wire at_last = level == last_lvl;
	wire go_start = run_bit && !run_q;

	// Level entered next, and whether a fresh entry happens
	logic enter;
	logic [LVL_W-1:0] next_level;
	always_comb begin
		enter = 1'b0;
		next_level = level;
		if (state == ST_RUN) begin
			if (count_done && !at_last) begin
				enter = 1'b1;
				next_level = level + 2'h1;
			end else if (!count_done && els_hit) begin
				enter = 1'b1;
				next_level = els_tgt;
			end
		end
	end
	wire [1:0] tstart = lvl_cfg[next_level][LV_TST +: 2];

	// ****************************************************
	// APB registers
	// ****************************************************
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ctrl <= 32'h0;
			term_cfg <= 32'h0;
			pat_cfg <= 32'h0;
			tmr1_lim <= 16'h0;
			tmr2_lim <= 16'h0;
			for (int i = 0; i < LEVELS; i++) begin
				lvl_cfg[i] <= 32'h0;
			end
		end else if (wr_en) begin
			if (hit_ctrl) begin
				ctrl <= pwdata_i;
			end else if (hit_term) begin
				term_cfg <= pwdata_i;
			end else if (hit_pat) begin
				pat_cfg <= pwdata_i;
			end else if (hit_t1) begin
				tmr1_lim <= pwdata_i[TMR_W-1:0];
			end else if (hit_t2) begin
				tmr2_lim <= pwdata_i[TMR_W-1:0];
			end else if (hit_lvl) begin
				lvl_cfg[lvl_idx] <= pwdata_i;
			end
		end
	end

	// Zero-wait slave; unmapped address answers with an error
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !hit_any;
			prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_mux : 32'h0;
		end
	end

	// ****************************************************
	// Sampling history and pattern duration
	// ****************************************************
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			prev_lines <= 8'h0;
			pat_run <= 8'h0;
		end else begin
			prev_lines <= lines_i;
			if (!pat_now) begin
				pat_run <= 8'h0;
			end else if (pat_run != 8'hff) begin
				pat_run <= pat_run + 8'h1;
			end
		end
	end

	// ****************************************************
	// Interval timers
	// ****************************************************
	// Timers saturate so a long absence never wraps back to small
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || go_start) begin
			first_interval_timer <= 16'h0;
			second_interval_timer <= 16'h0;
			t1_on <= 1'b0;
			t2_on <= 1'b0;
		end else begin
			if (enter && tstart[0]) begin
				first_interval_timer <= 16'h0;
				t1_on <= 1'b1;
			end else if (t1_on && first_interval_timer != 16'hffff) begin
				first_interval_timer <= first_interval_timer + 16'h1;
			end
			if (enter && tstart[1]) begin
				second_interval_timer <= 16'h0;
				t2_on <= 1'b1;
			end else if (t2_on && second_interval_timer != 16'hffff) begin
				second_interval_timer <= second_interval_timer + 16'h1;
			end
		end
	end

	// ****************************************************
	// Sequencer
	// ****************************************************
	// A run starts on the rising edge of the run bit; clearing it stops
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			level <= 2'h0;
			occ <= 16'h0;
			run_q <= 1'b0;
			trigger_o <= 1'b0;
		end else begin
			run_q <= run_bit;
			if (!run_bit) begin
				state <= ST_IDLE;
				trigger_o <= 1'b0;
			end else if (go_start) begin
				state <= ST_RUN;
				level <= 2'h0;
				occ <= 16'h0;
				trigger_o <= 1'b0;
			end else if (state == ST_RUN) begin
				if (count_done && at_last) begin
					state <= ST_TRIG;
					trigger_o <= 1'b1;
				end else if (enter) begin
					level <= next_level;
					occ <= 16'h0;
				end else if (pri_hit) begin
					occ <= occ + 16'h1;
				end
			end
		end
	end
endmodule // trig_seq
`default_nettype wire

// >>> dv/sut_lines.sv
// Model of the sampled signal lines of the system under test.
// Assumes the bench calls drive; lines change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module sut_lines
	import trig_seq_pkg::*;
(
	// Clock
	input wire logic clock_i,
	// Lines towards the sequencer
	output logic [LINES-1:0] lines_o
);
	// ****************************************************
	// Line driving
	// ****************************************************
	initial lines_o = '0;
	// Set one line, hold it n cycles, settle past the edge
	task automatic drive(input int ln, input logic v, input int n);
		@(posedge clock_i);
		lines_o[ln] <= v;
		repeat (n) @(posedge clock_i);
		#1;
	endtask
endmodule // sut_lines
`default_nettype wire

// >>> dv/trig_seq_sva.sv
// Checker for the trigger sequencer, watching its top ports only.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module trig_seq_sva
	import trig_seq_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Lines and trigger
	input wire logic [LINES-1:0] lines_i,
	input wire logic trigger_o
);
	// ****************************************************
	// Decode
	// ****************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Setup cycles, mapped offsets, run-bit clears
	wire logic setup = psel_i && !penable_i;
	wire logic mapped = paddr_i inside {CTRL_OFF, STAT_OFF, TERM_OFF,
		PAT_OFF, TMR1_OFF, TMR2_OFF, 8'h20, 8'h24, 8'h28, 8'h2c};
	wire logic stop = psel_i && penable_i && pwrite_i &&
		paddr_i == CTRL_OFF && !pwdata_i[0];
	sequence s_setup;
		setup;
	endsequence
	sequence s_answer;
		pready_o && psel_i && penable_i;
	endsequence
	// ****************************************************
	// Properties
	// ****************************************************
	property p_ready;
		s_setup |=> s_answer;
	endproperty
	a_ready: assert property (p_ready) else $error("no answer");
	property p_once;
		pready_o |=> !pready_o;
	endproperty
	a_once: assert property (p_once) else $error("ready held");
	property p_err;
		s_setup ##0 !mapped |=> pslverr_o;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_no_err;
		s_setup ##0 mapped |=> !pslverr_o;
	endproperty
	a_no_err: assert property (p_no_err) else $error("false error");
	property p_rd_idle;
		!pready_o |-> prdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray data");
	property p_hold;
		trigger_o && !stop && !$past(stop) |=> trigger_o;
	endproperty
	a_hold: assert property (p_hold) else $error("trigger lost");
	property p_clear;
		stop |=> ##1 !trigger_o [*2];
	endproperty
	a_clear: assert property (p_clear) else $error("trigger kept");
	property p_stat;
		s_setup ##0 !pwrite_i && paddr_i == STAT_OFF && trigger_o
			|=> prdata_o[1:0] == 2'h2;
	endproperty
	a_stat: assert property (p_stat) else $error("bad state");
endmodule // trig_seq_sva
`default_nettype wire

// >>> dv/tb_trig_seq.sv
// Testbench for the trigger sequencer: APB tasks and line stimulus.
// Assumes a 100 MHz clock and the sut_lines model on the lines.
`timescale 1ns/1ps
`default_nettype none
module tb_trig_seq;
	import trig_seq_pkg::*;
	// ****************************************************
	// Signals and instances
	// ****************************************************
	logic clock, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, trig, rerr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic [LINES-1:0] lines;
	int checks = 0, fail_count = 0, cyc = 0;
	sut_lines u_sut (.clock_i(clock), .lines_o(lines));
	trig_seq u_dut (.clock_i(clock), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .lines_i(lines), .trigger_o(trig));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Hang guard, far above the few thousand cycles needed
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	// ****************************************************
	// Tasks
	// ****************************************************
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Rerun needs the run bit to go low first
	task automatic run(input logic [1:0] last);
		apb(1'b1, CTRL_OFF, 32'h0);
		apb(1'b1, CTRL_OFF, {26'h0, last, 4'h1});
	endtask
	function automatic logic [31:0] lv(logic [3:0] p, logic [3:0] e,
		logic [1:0] t, logic [1:0] s, logic [15:0] c);
		return {c, 4'h0, s, t, e, p};
	endfunction
	task automatic test_done();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************************************************
	// Tests
	// ****************************************************
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		// Reset state, then an unmapped offset
		apb(1'b0, STAT_OFF, 32'h0);
		chk(rdata, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(rdata, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		$display("test reset done");
		// Each edge mode on line 0, single occurrence
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, TERM_OFF, 32'(m) << TERM_E1_MODE);
			apb(1'b1, LVL_BASE, lv(T_E1, T_NONE, 0, 0, 1));
			run(0);
			u_sut.drive(0, 1'b1, 3);
			chk(trig, m != 2);
			u_sut.drive(0, 1'b0, 3);
			chk(trig, 1);
		end
		$display("test modes done");
		// Tenth rising edge only
		apb(1'b1, TERM_OFF, 32'h10);
		apb(1'b1, LVL_BASE, lv(T_E1, T_NONE, 0, 0, EDGE_COUNT_EX));
		run(0);
		for (int i = 1; i <= 10; i++) begin
			u_sut.drive(0, 1'b1, 2);
			u_sut.drive(0, 1'b0, 2);
			chk(trig, i == 10);
		end
		apb(1'b0, STAT_OFF, 32'h0);
		chk(rdata[1:0], 2);
		$display("test count done");
		// Pattern must outlast its duration
		apb(1'b1, PAT_OFF, 32'h0008_0101);
		apb(1'b1, LVL_BASE, lv(T_PAT, T_NONE, 0, 0, 1));
		run(0);
		u_sut.drive(0, 1'b1, 6);
		u_sut.drive(0, 1'b0, 3);
		chk(trig, 0);
		u_sut.drive(0, 1'b1, 12);
		chk(trig, 1);
		u_sut.drive(0, 1'b0, 1);
		$display("test pattern done");
		// Select, then data inside or outside the timer limit
		apb(1'b1, PAT_OFF, 32'h0000_0202);
		apb(1'b1, TMR1_OFF, ACK_LIMIT_CYC);
		apb(1'b1, LVL_BASE + 8'h04, lv(T_TMR1, T_PAT, 0, 1, 1));
		apb(1'b1, LVL_BASE, lv(T_E1, T_NONE, 0, 0, 1));
		run(1);
		u_sut.drive(0, 1'b1, 2);
		apb(1'b0, STAT_OFF, 32'h0);
		chk(rdata[5:4], 1);
		u_sut.drive(1, 1'b1, 1500);
		u_sut.drive(1, 1'b0, 2);
		apb(1'b0, STAT_OFF, 32'h0);
		chk({trig, rdata[5:4]}, 0);
		u_sut.drive(0, 1'b0, 2);
		u_sut.drive(0, 1'b1, 1700);
		chk(trig, 1);
		u_sut.drive(0, 1'b0, 1);
		$display("test timer done");
		// Pulse widths against both limits
		apb(1'b1, TERM_OFF, 32'h0000_2212);
		apb(1'b1, TMR1_OFF, MIN_WID_CYC);
		apb(1'b1, TMR2_OFF, MAX_WID_CYC);
		apb(1'b1, LVL_BASE + 8'h04, lv(T_E2, T_NONE, 0, 3, 1));
		apb(1'b1, LVL_BASE + 8'h08, lv(T_T1LO_T2HI, T_ANY, 0, 0, 1));
		for (int k = 0; k < 3; k++) begin
			run(2);
			u_sut.drive(2, 1'b1, k == 0 ? 75 : k == 1 ? 30 : 150);
			u_sut.drive(2, 1'b0, 3);
			apb(1'b0, STAT_OFF, 32'h0);
			chk({trig, rdata[5:4]}, k == 0 ? 3'h0 : 3'h6);
		end
		$display("test pulse done");
		test_done();
	end
endmodule // tb_trig_seq
bind trig_seq trig_seq_sva u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .lines_i(lines_i),
	.trigger_o(trigger_o));
`default_nettype wire
